// ==== design/mtm_cfg.svh ====
`ifndef MTM_CFG_SVH
`define MTM_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte registers on the plain register port)
// ---------------------------------------------------------------
`define MTM_ADDR_W 3
`define MTM_OFF_CTRL 3'h0
`define MTM_OFF_CLKCFG 3'h1
`define MTM_OFF_CNT_HI 3'h2
`define MTM_OFF_CNT_LO 3'h3
`define MTM_OFF_MOD_HI 3'h4
`define MTM_OFF_MOD_LO 3'h5

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MTM_CTRL_FLAG_BIT 7
`define MTM_CTRL_CLR_BIT 5
`define MTM_CTRL_HALT_BIT 4
`define MTM_CLK_SRC_HI 5
`define MTM_CLK_SRC_LO 4
`define MTM_CLK_PS_HI 3
`define MTM_CLK_PS_LO 0

// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define MTM_SRC_RST 2'h0
`define MTM_PS_RST 4'h0
`define MTM_PS_MAX 4'h8
`define MTM_HALT_RST 1'b1
`define MTM_BYTE_ZERO 8'h00
`define MTM_CNT_ZERO 16'h0000
`define MTM_CNT_TOP 16'hFFFF

`endif

// ==== design/mtm_pkg.sv ====
// ---------------------------------------------------------------
// Types shared by the modulo timer
// ---------------------------------------------------------------
package mtm_pkg;

  // Count source encodings of the source_select field
  typedef enum logic [1:0] {
    SRC_BUS = 2'b00,
    SRC_FIXED = 2'b01,
    SRC_EXT_FALL = 2'b10,
    SRC_EXT_RISE = 2'b11
  } mtm_src_t;

  // Read coherency states: which byte is still owed from the buffer
  typedef enum logic [1:0] {
    LAT_IDLE = 2'b00,
    LAT_WAIT_LO = 2'b01,
    LAT_WAIT_HI = 2'b10
  } mtm_lat_t;

endpackage : mtm_pkg

// ==== design/mtm_timer.sv ====
// Summary of operation
// [RULE1] Source select picks bus, fixed, ext fall, ext rise
// [RULE2] Source change keeps count, continues on new source
// [RULE3] Prescale divides by two to code power
// [RULE4] Prescale codes above eight divide by 256
// [RULE5] Prescale change keeps count, new rate applies
// [RULE6] Clock config upper two bits read zero
// [RULE7] Counter bytes read-only, writes ignored, reset zero
// [RULE8] Counter byte read latches both for coherence
// [RULE9] Read latch idles on reset and clear
// [RULE10] Debug halt freezes read latch state
// [RULE11] Debug halt reads return live counter
// [RULE12] Zero wrap limit means free-running counter
// [RULE13] Wrap limit loads after both bytes, at next wrap
// [RULE14] First complete load clears counter, applies immediately
// [RULE15] Clear command applies loaded wrap limit at once
// [RULE16] Clear command resets wrap limit write latch
// [RULE17] Debug halt freezes wrap limit write latch
// [RULE18] Debug halt writes go direct, clear counter
// [RULE19] Wrap limit reads return value in effect
// [RULE20] Wrap limit bytes read-write, reset zero
// [RULE21] Match wraps to zero, sets wrap flag
// [RULE22] Clear bit zeroes counter and flag, reads zero
// [RULE23] External input synchronised, one enable per edge
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mtm_cfg.svh"

module mtm_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`MTM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Count sources from outside the clock domain
  input wire logic fixed_freq_clock,
  input wire logic ext_count_input,
  // Debug halt level from the core, same clock
  input wire logic debug_halt_mode,
  // Status outputs
  output logic wrap_flag_q,
  output logic wrap_match_q
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [1:0] src_q;
  logic [3:0] ps_q;
  logic count_halt_q;
  logic flag_arm_q;
  logic [7:0] presc_q;
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic [15:0] pend_q;
  logic pend_valid_q;
  logic [7:0] buf_hi_q;
  logic [7:0] buf_lo_q;
  logic seen_hi_q;
  logic seen_lo_q;
  logic first_done_q;
  logic [15:0] rbuf_q;
  mtm_pkg::mtm_lat_t lat_q;
  logic [2:0] fix_sync_q;
  logic [2:0] ext_sync_q;

  logic wr_ctrl, wr_clk, wr_mhi, wr_mlo;
  logic rd_ctrl, rd_chi, rd_clo;
  logic clear_cmd, run, src_tick, cnt_tick, at_wrap, wrap_evt;
  logic fix_rise, ext_rise, ext_fall;
  logic [3:0] ps_eff;
  logic [7:0] ps_mask;
  logic mod_complete, first_load, dbg_mod_wr;
  logic [15:0] mod_new;
  logic [7:0] rd_mux;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == `MTM_OFF_CTRL);
  assign wr_clk = reg_wr && (reg_addr == `MTM_OFF_CLKCFG);
  assign wr_mhi = reg_wr && (reg_addr == `MTM_OFF_MOD_HI);
  assign wr_mlo = reg_wr && (reg_addr == `MTM_OFF_MOD_LO);
  assign rd_ctrl = reg_rd && (reg_addr == `MTM_OFF_CTRL);
  assign rd_chi = reg_rd && (reg_addr == `MTM_OFF_CNT_HI);
  assign rd_clo = reg_rd && (reg_addr == `MTM_OFF_CNT_LO);
  // Clear is a pulse from the write itself; nothing is stored for it
  assign clear_cmd = wr_ctrl && reg_wdata[`MTM_CTRL_CLR_BIT]; // [RULE22]

  // ---------------------------------------------------------------
  // Control and clock configuration registers
  // ---------------------------------------------------------------
  // Halt bit comes out of reset set so the counter sits still
  always_ff @(posedge clk) begin
    if (rst) begin
      count_halt_q <= `MTM_HALT_RST;
    end else if (wr_ctrl) begin
      count_halt_q <= reg_wdata[`MTM_CTRL_HALT_BIT];
    end
  end

  // Source and prescale fields; neither write touches the count
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= `MTM_SRC_RST; // [RULE1]
      ps_q <= `MTM_PS_RST; // [RULE3]
    end else if (wr_clk) begin
      src_q <= reg_wdata[`MTM_CLK_SRC_HI:`MTM_CLK_SRC_LO]; // [RULE2]
      ps_q <= reg_wdata[`MTM_CLK_PS_HI:`MTM_CLK_PS_LO]; // [RULE5]
    end
  end

  // ---------------------------------------------------------------
  // Source synchronisers and edge detectors
  // ---------------------------------------------------------------
  // Stage 0 feeds stage 1 only; stage 2 is the previous value for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      fix_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
    end else begin
      fix_sync_q <= {fix_sync_q[1:0], fixed_freq_clock};
      ext_sync_q <= {ext_sync_q[1:0], ext_count_input}; // [RULE23]
    end
  end

  // Inputs must stay below a quarter of clk so no edge is missed
  assign fix_rise = fix_sync_q[1] && !fix_sync_q[2];
  assign ext_rise = ext_sync_q[1] && !ext_sync_q[2]; // [RULE23]
  assign ext_fall = !ext_sync_q[1] && ext_sync_q[2]; // [RULE23]

  // Source multiplexer, one enable per qualifying event
  always_comb begin
    case (mtm_pkg::mtm_src_t'(src_q))
      mtm_pkg::SRC_BUS: src_tick = 1'b1; // [RULE1]
      mtm_pkg::SRC_FIXED: src_tick = fix_rise; // [RULE1]
      mtm_pkg::SRC_EXT_FALL: src_tick = ext_fall; // [RULE1]
      mtm_pkg::SRC_EXT_RISE: src_tick = ext_rise; // [RULE1]
      default: src_tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  // Counting stops under software halt and under debug halt
  assign run = !count_halt_q && !debug_halt_mode;
  assign ps_eff = (ps_q > `MTM_PS_MAX) ? `MTM_PS_MAX : ps_q; // [RULE4]
  assign ps_mask = 8'((9'h001 << ps_eff) - 9'h001); // [RULE3]
  assign cnt_tick = run && src_tick && ((presc_q & ps_mask) == ps_mask); // [RULE3]

  // Free-running divider; a new code takes effect on the next match
  always_ff @(posedge clk) begin
    if (rst || clear_cmd) begin
      presc_q <= `MTM_BYTE_ZERO;
    end else if (run && src_tick) begin
      presc_q <= presc_q + 8'h01; // [RULE5]
    end
  end

  // ---------------------------------------------------------------
  // Main counter
  // ---------------------------------------------------------------
  // Zero limit wraps at the top of the range instead
  assign at_wrap = (mod_q != `MTM_CNT_ZERO) ? (cnt_q == mod_q) : (cnt_q == `MTM_CNT_TOP); // [RULE12]
  assign wrap_evt = cnt_tick && at_wrap; // [RULE21]

  // Counter clears win over counting; writes to the counter bytes never reach it
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= `MTM_CNT_ZERO; // [RULE7]
    end else if (clear_cmd || first_load || dbg_mod_wr) begin
      cnt_q <= `MTM_CNT_ZERO; // [RULE22]
    end else if (cnt_tick) begin
      cnt_q <= at_wrap ? `MTM_CNT_ZERO : cnt_q + 16'h0001; // [RULE21]
    end
  end

  // Match output pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_match_q <= 1'b0;
    end else begin
      wrap_match_q <= wrap_evt;
    end
  end

  // ---------------------------------------------------------------
  // Wrap flag with two-step clear
  // ---------------------------------------------------------------
  // Arm on a control read while set; any new wrap disarms
  always_ff @(posedge clk) begin
    if (rst || clear_cmd || wrap_evt) begin
      flag_arm_q <= 1'b0;
    end else if (rd_ctrl && wrap_flag_q) begin
      flag_arm_q <= 1'b1;
    end else if (wr_ctrl) begin
      flag_arm_q <= 1'b0;
    end
  end

  // A wrap in the two-step clearing cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_flag_q <= 1'b0;
    end else if (clear_cmd) begin
      wrap_flag_q <= 1'b0; // [RULE22]
    end else if (wrap_evt) begin
      wrap_flag_q <= 1'b1; // [RULE21]
    end else if (wr_ctrl && !reg_wdata[`MTM_CTRL_FLAG_BIT] && flag_arm_q) begin
      wrap_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Wrap limit write buffering
  // ---------------------------------------------------------------
  assign dbg_mod_wr = debug_halt_mode && (wr_mhi || wr_mlo); // [RULE18]
  assign mod_complete = !debug_halt_mode && ((wr_mhi && seen_lo_q) || (wr_mlo && seen_hi_q)); // [RULE13]
  assign first_load = mod_complete && !first_done_q; // [RULE14]
  assign mod_new = wr_mhi ? {reg_wdata, buf_lo_q} : {buf_hi_q, reg_wdata};

  // Byte buffers take normal-mode writes only
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_hi_q <= `MTM_BYTE_ZERO;
      buf_lo_q <= `MTM_BYTE_ZERO;
    end else if (!debug_halt_mode) begin
      if (wr_mhi) begin
        buf_hi_q <= reg_wdata; // [RULE13]
      end
      if (wr_mlo) begin
        buf_lo_q <= reg_wdata; // [RULE13]
      end
    end
  end

  // Write latch sequence: which bytes are waiting for their partner
  always_ff @(posedge clk) begin
    if (rst || clear_cmd) begin
      seen_hi_q <= 1'b0; // [RULE16]
      seen_lo_q <= 1'b0; // [RULE16]
    end else if (debug_halt_mode) begin
      seen_hi_q <= seen_hi_q; // [RULE17]
      seen_lo_q <= seen_lo_q; // [RULE17]
    end else if (mod_complete) begin
      seen_hi_q <= 1'b0;
      seen_lo_q <= 1'b0;
    end else begin
      seen_hi_q <= seen_hi_q || wr_mhi;
      seen_lo_q <= seen_lo_q || wr_mlo;
    end
  end

  // Only chip reset re-arms the immediate first load
  always_ff @(posedge clk) begin
    if (rst) begin
      first_done_q <= 1'b0;
    end else if (mod_complete) begin
      first_done_q <= 1'b1; // [RULE14]
    end
  end

  // Pending value; mirrors direct debug writes so a later clear keeps them
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= `MTM_CNT_ZERO;
      pend_valid_q <= 1'b0;
    end else if (dbg_mod_wr) begin
      pend_q <= wr_mhi ? {reg_wdata, mod_q[7:0]} : {mod_q[15:8], reg_wdata};
      pend_valid_q <= 1'b0;
    end else if (mod_complete) begin
      pend_q <= mod_new;
      pend_valid_q <= first_done_q; // [RULE13]
    end else if (clear_cmd || wrap_evt) begin
      pend_valid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Wrap limit in effect
  // ---------------------------------------------------------------
  // Normal loads after the first wait for the next wrap so the current cycle ends cleanly
  always_ff @(posedge clk) begin
    if (rst) begin
      mod_q <= `MTM_CNT_ZERO; // [RULE20]
    end else if (dbg_mod_wr && wr_mhi) begin
      mod_q[15:8] <= reg_wdata; // [RULE18]
    end else if (dbg_mod_wr) begin
      mod_q[7:0] <= reg_wdata; // [RULE18]
    end else if (clear_cmd) begin
      mod_q <= pend_q; // [RULE15]
    end else if (first_load) begin
      mod_q <= mod_new; // [RULE14]
    end else if (wrap_evt && pend_valid_q) begin
      mod_q <= pend_q; // [RULE13]
    end
  end

  // ---------------------------------------------------------------
  // Counter read coherency
  // ---------------------------------------------------------------
  // Snapshot taken by the first byte read of a pair
  always_ff @(posedge clk) begin
    if (rst) begin
      rbuf_q <= `MTM_CNT_ZERO;
    end else if (!debug_halt_mode && (rd_chi || rd_clo) && (lat_q == mtm_pkg::LAT_IDLE)) begin
      rbuf_q <= cnt_q; // [RULE8]
    end
  end

  // Repeat reads of the same byte keep the snapshot frozen
  always_ff @(posedge clk) begin
    if (rst || clear_cmd) begin
      lat_q <= mtm_pkg::LAT_IDLE; // [RULE9]
    end else if (debug_halt_mode) begin
      lat_q <= lat_q; // [RULE10]
    end else begin
      case (lat_q)
        mtm_pkg::LAT_IDLE: begin
          if (rd_chi) begin
            lat_q <= mtm_pkg::LAT_WAIT_LO; // [RULE8]
          end else if (rd_clo) begin
            lat_q <= mtm_pkg::LAT_WAIT_HI; // [RULE8]
          end
        end
        mtm_pkg::LAT_WAIT_LO: begin
          if (rd_clo) begin
            lat_q <= mtm_pkg::LAT_IDLE;
          end
        end
        mtm_pkg::LAT_WAIT_HI: begin
          if (rd_chi) begin
            lat_q <= mtm_pkg::LAT_IDLE;
          end
        end
        default: lat_q <= mtm_pkg::LAT_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Idle reads show the live value, which equals the snapshot taken now
  always_comb begin
    rd_mux = `MTM_BYTE_ZERO;
    case (reg_addr)
      `MTM_OFF_CTRL: begin
        rd_mux[`MTM_CTRL_FLAG_BIT] = wrap_flag_q;
        rd_mux[`MTM_CTRL_HALT_BIT] = count_halt_q; // Clear bit reads zero
      end
      `MTM_OFF_CLKCFG: rd_mux = {2'b00, src_q, ps_q}; // [RULE6]
      `MTM_OFF_CNT_HI: begin
        if (debug_halt_mode || lat_q == mtm_pkg::LAT_IDLE) begin
          rd_mux = cnt_q[15:8]; // [RULE11]
        end else begin
          rd_mux = rbuf_q[15:8]; // [RULE8]
        end
      end
      `MTM_OFF_CNT_LO: begin
        if (debug_halt_mode || lat_q == mtm_pkg::LAT_IDLE) begin
          rd_mux = cnt_q[7:0]; // [RULE11]
        end else begin
          rd_mux = rbuf_q[7:0]; // [RULE8]
        end
      end
      `MTM_OFF_MOD_HI: rd_mux = mod_q[15:8]; // [RULE19]
      `MTM_OFF_MOD_LO: rd_mux = mod_q[7:0]; // [RULE19]
      default: rd_mux = `MTM_BYTE_ZERO;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= `MTM_BYTE_ZERO;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : `MTM_BYTE_ZERO;
    end
  end

endmodule : mtm_timer
`default_nettype wire

// ==== dv/mtm_timer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mtm_cfg.svh"
module mtm_timer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`MTM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Count sources and debug
  input wire logic fixed_freq_clock,
  input wire logic ext_count_input,
  input wire logic debug_halt_mode,
  // Status
  input wire logic wrap_flag_q,
  input wire logic wrap_match_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadow of the clock config fields
  // ----------------------------------------
  logic [5:0] cfg_q;
  // Tracks the last config write, so readback is checked against what was written
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= 6'h00;
    end else if (reg_wr && reg_addr == `MTM_OFF_CLKCFG) begin
      cfg_q <= reg_wdata[5:0];
    end
  end
  a_cfg_read_back: assert property (
    reg_rd && reg_addr == `MTM_OFF_CLKCFG |=> reg_rdata_q == {2'b00, cfg_q})
    else $error("config readback wrong");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > `MTM_OFF_MOD_LO |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_clr_reads_zero: assert property (
    reg_rd && reg_addr == `MTM_OFF_CTRL |=> !reg_rdata_q[5])
    else $error("clear bit read as one");
  a_clear_drops_flag: assert property (
    reg_wr && reg_addr == `MTM_OFF_CTRL && reg_wdata[5] |=> !wrap_flag_q)
    else $error("clear left wrap flag set");
  a_flag_holds: assert property (
    wrap_flag_q && !reg_wr |=> wrap_flag_q)
    else $error("wrap flag dropped without write");
  a_rise_gives_match: assert property (
    $rose(wrap_flag_q) |-> wrap_match_q)
    else $error("flag rose without match pulse");
  a_match_after_flag: assert property (
    wrap_match_q && !$past(reg_wr) |-> wrap_flag_q)
    else $error("match pulse without flag");
  // Debug halt stops the prescaler, so no wrap can be reported after it
  a_halt_no_match: assert property (debug_halt_mode |=> !wrap_match_q)
    else $error("wrap while debug halted");
endmodule : mtm_timer_checker
`default_nettype wire

// ==== dv/mtm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mtm_cfg.svh"
module mtm_host (
  // Clock
  input wire logic clk,
  // Register port, master side
  output logic [`MTM_ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q
);
  // Idle bus at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; data inverted after so a stale byte is never mistaken for live
  task automatic wr(input logic [`MTM_ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  // One read cycle; data stands only in the cycle after the strobe
  task automatic rd(input logic [`MTM_ADDR_W-1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rd
endmodule : mtm_host
`default_nettype wire

// ==== dv/mtm_timer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mtm_cfg.svh"
module mtm_timer_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fixed_freq_clock = 1'b0;
  logic ext_count_input = 1'b0;
  logic debug_halt_mode = 1'b0;
  logic [`MTM_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_q;
  logic wrap_flag_q;
  logic wrap_match_q;
  logic [7:0] v, w, h, l;
  logic [15:0] v1, v3;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int gen_q = 0;
  int n, c1, c2, c3, ps, r;
  int sc[4] = '{1, 12, 8, 8};
  int pss[3];
  mtm_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  mtm_timer uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .fixed_freq_clock(fixed_freq_clock), .ext_count_input(ext_count_input),
    .debug_halt_mode(debug_halt_mode), .wrap_flag_q(wrap_flag_q), .wrap_match_q(wrap_match_q));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Slow count sources: fixed clock period 12 cycles, external pin period 8
  always @(posedge clk) begin
    gen_q <= gen_q + 1;
    fixed_freq_clock <= (gen_q % 12) < 6;
    ext_count_input <= (gen_q % 8) < 4;
  end
  // Cycle counter doubles as the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Cycles between wrap pulses; the first interval may straddle a config change
  task automatic period(output int p);
    repeat (3) begin
      p = 0;
      do begin
        @(posedge clk);
        #1;
        p++;
      end while (wrap_match_q !== 1'b1 && p < 5000);
    end
  endtask : period
  function automatic int exp_period(input int lim, input int pcode, input int scale);
    return (lim + 1) * scale * (1 << ((pcode > 8) ? 8 : pcode));
  endfunction : exp_period
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(86);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    // Reset values, halt bit set, unmapped places read zero
    for (int a = 0; a < 8; a++) begin
      host.rd(a[2:0], v);
      chk("reset value", (a == 0) ? 8'h10 : 8'h00, v);
    end
    // Counter bytes ignore writes
    host.wr(`MTM_OFF_CNT_HI, 8'($urandom));
    host.wr(`MTM_OFF_CNT_LO, 8'($urandom));
    host.rd(`MTM_OFF_CNT_HI, h);
    host.rd(`MTM_OFF_CNT_LO, l);
    chk("counter after write", 16'h0000, {h, l});
    // Random config values read back with the unused bits clear
    repeat (4) begin
      w = 8'($urandom);
      host.wr(`MTM_OFF_CLKCFG, w);
      host.rd(`MTM_OFF_CLKCFG, v);
      chk("config", {2'b00, w[5:0]}, v);
    end
    // First full limit load after reset takes effect at once, then start counting
    host.wr(`MTM_OFF_MOD_HI, 8'h00);
    host.wr(`MTM_OFF_MOD_LO, 8'h03);
    host.rd(`MTM_OFF_MOD_HI, h);
    host.rd(`MTM_OFF_MOD_LO, l);
    chk("first limit", 16'h0003, {h, l});
    host.wr(`MTM_OFF_CTRL, 8'h00);
    // Every source, switched while running
    for (int s = 0; s < 4; s++) begin
      host.wr(`MTM_OFF_CLKCFG, {2'b00, 2'(s), 4'h0});
      period(n);
      chk("source period", exp_period(3, 0, sc[s]), n);
    end
    // Prescale codes including one above the defined range
    pss = '{2, 8, 9 + ($urandom % 7)};
    foreach (pss[i]) begin
      ps = pss[i];
      host.wr(`MTM_OFF_CLKCFG, {4'h0, 4'(ps)});
      period(n);
      chk("prescale period", exp_period(3, ps, 1), n);
    end
    // Buffered limit waits for a wrap; clear applies it and restarts the write pairing
    period(n);
    host.wr(`MTM_OFF_MOD_HI, 8'h00);
    host.wr(`MTM_OFF_MOD_LO, 8'h00);
    host.rd(`MTM_OFF_MOD_LO, l);
    chk("limit before wrap", 8'h03, l);
    host.wr(`MTM_OFF_MOD_HI, 8'h01);
    host.wr(`MTM_OFF_CTRL, 8'h20);
    host.wr(`MTM_OFF_MOD_LO, 8'h02);
    host.wr(`MTM_OFF_CTRL, 8'h20);
    host.rd(`MTM_OFF_MOD_HI, h);
    host.rd(`MTM_OFF_MOD_LO, l);
    chk("limit after clear", 16'h0000, {h, l});
    host.wr(`MTM_OFF_CLKCFG, 8'h00);
    // Coherent reads in both byte orders while counting every cycle
    host.rd(`MTM_OFF_CNT_LO, l);
    c1 = cyc;
    host.rd(`MTM_OFF_CNT_LO, v);
    chk("low reread", l, v);
    repeat (300) @(posedge clk);
    #1;
    host.rd(`MTM_OFF_CNT_HI, h);
    v1 = {h, l};
    host.rd(`MTM_OFF_CNT_HI, h);
    c2 = cyc;
    host.rd(`MTM_OFF_CNT_LO, l);
    chk("count advance", c2 - c1, 32'({h, l} - v1));
    // Pair begun, then debug halt: live reads, direct limit write clears the counter
    host.rd(`MTM_OFF_CNT_LO, v);
    c3 = cyc;
    v3 = {h, l} + 16'(c3 - c2);
    chk("pair start live", v3[7:0], v);
    debug_halt_mode <= 1'b1;
    host.wr(`MTM_OFF_MOD_LO, 8'h07);
    host.rd(`MTM_OFF_MOD_HI, h);
    host.rd(`MTM_OFF_MOD_LO, l);
    chk("halt limit", 16'h0007, {h, l});
    host.rd(`MTM_OFF_CNT_HI, h);
    host.rd(`MTM_OFF_CNT_LO, l);
    chk("halt live count", 16'h0000, {h, l});
    debug_halt_mode <= 1'b0;
    host.rd(`MTM_OFF_CNT_HI, h);
    chk("pair after halt", v3[15:8], h);
    period(n);
    chk("halt limit period", exp_period(7, 0, 1), n);
    // Wraps have set the flag; a clear drops it and the clear bit reads zero
    host.rd(`MTM_OFF_CTRL, v);
    chk("flag after wraps", 8'h80, v);
    host.wr(`MTM_OFF_CTRL, 8'h20);
    host.rd(`MTM_OFF_CTRL, v);
    chk("flag after clear", 8'h00, v);
    results();
  end
endmodule : mtm_timer_bench
// Checker watches the top ports
bind mtm_timer mtm_timer_checker chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .fixed_freq_clock(fixed_freq_clock), .ext_count_input(ext_count_input),
  .debug_halt_mode(debug_halt_mode), .wrap_flag_q(wrap_flag_q), .wrap_match_q(wrap_match_q));
`default_nettype wire
